//--- lpms_sequencer.sv
// low-power mode sequencer top: clock gating, oscillator and pll control
//
// Behaviour
// - clock-gated entry keeps system clock 32 cycles before gating
// - clock-gated mode stops peripheral clocks, pll keeps running
// - external clock output low 32 to 45 cycles after entry instruction
// - clock-gated wake, flash active or ram: resume within 100 cycles
// - clock-gated wake, flash asleep: resume within 1125 cycles
// - bound ends when next instruction starts; interrupt service adds more
// - deep-stop entry keeps clock 32 cycles, then core clock and pll off
// - deep-stop stops peripherals, pll; crystal source also stops oscillator
// - deep-stop wake pin falling edge turns oscillator on without clock
// - wake pin release starts 131072-cycle pll lock, then core clock on
// - after pll lock with flash asleep resume within 1125 cycles
// - core clock back on: leave deep-stop, service wake interrupt if enabled
// - clock-gated qualified wake needs two plus qualification count cycles held low
`timescale 1ns/1ps
`default_nettype none
module lpms_sequencer
    import lpms_pkg::*;
(
    // clock and reset
    input  wire logic              mclk_i,
    input  wire logic              rst_n_i,
    // cpu side
    input  wire logic              lp_entry_i,
    input  wire logic              mode_sel_i,
    input  wire logic              flash_asleep_i,
    input  wire logic              crystal_src_i,
    input  wire logic              wake_irq_en_i,
    // wake qualification
    input  wire logic              qual_en_i,
    input  wire logic [QUAL_W-1:0] wake_qual_count_i,
    // pins
    input  wire logic              wake_pin_n_i,
    input  wire logic              reset_pin_n_i,
    // clock side
    input  wire logic              osc_stable_i,
    // outputs
    output logic                   system_clock_en_o,
    output logic                   periph_clock_en_o,
    output logic                   external_clock_output_en_o,
    output logic                   core_clock_input_en_o,
    output logic                   osc_en_o,
    output logic                   pll_en_o,
    output logic                   cpu_resume_o,
    output logic                   wake_irq_o,
    output logic                   osc_start_async_o
);
    typedef struct packed {
        lpms_state_e state;
        logic        mode;
        logic        sys_en;
        logic        per_en;
        logic        xclk_en;
        logic        core_en;
        logic        osc_en;
        logic        pll_en;
        logic        resume;
        logic        irq;
    } lpms_seq_s;

    lpms_seq_s        r;
    lpms_seq_s        next_r;
    logic             cnt_load;
    logic [CNT_W-1:0] cnt_value;
    logic             cnt_zero;
    logic             wake_q;
    logic             osc_async;

    function automatic logic [CNT_W-1:0] lpms_resume_cnt(input logic asleep);
        lpms_resume_cnt = asleep ? SLOW_RESUME : FAST_RESUME;
    endfunction : lpms_resume_cnt

    lpms_counter u_cnt (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .load_i  (cnt_load),
        .value_i (cnt_value),
        .zero_o  (cnt_zero)
    );

    lpms_wake_qual u_qual (
        .mclk_i       (mclk_i),
        .rst_n_i      (rst_n_i),
        .qual_en_i    (qual_en_i && (r.mode == MODE_CLK_GATED)),
        .qual_count_i (wake_qual_count_i),
        .wake_n_i     (wake_pin_n_i),
        .wake_o       (wake_q)
    );

    // combinational oscillator enable, no clock needed in deep stop
    assign osc_async = r.state[3] && !wake_pin_n_i;

    always_comb begin
        next_r    = r;
        cnt_load  = 1'b0;
        cnt_value = '0;
        next_r.resume = 1'b0;
        next_r.irq    = 1'b0;
        unique case (r.state)
            LPMS_RUN: begin
                if (lp_entry_i) begin
                    next_r.mode  = mode_sel_i;
                    next_r.state = LPMS_DRAIN;
                    cnt_load     = 1'b1;
                    cnt_value    = DRAIN_CNT;
                end
            end
            LPMS_DRAIN: begin
                if (cnt_zero) begin
                    next_r.sys_en  = 1'b0;
                    next_r.xclk_en = 1'b0;
                    next_r.per_en  = 1'b0;
                    if (r.mode == MODE_DEEP_STOP) begin
                        next_r.pll_en  = 1'b0;
                        next_r.core_en = 1'b0;
                        next_r.osc_en  = !crystal_src_i;
                        next_r.state   = LPMS_STOP;
                    end else begin
                        next_r.state = LPMS_GATED;
                    end
                end
            end
            LPMS_GATED: begin
                if (wake_q || !reset_pin_n_i) begin
                    next_r.sys_en  = 1'b1;
                    next_r.xclk_en = 1'b1;
                    next_r.per_en  = 1'b1;
                    next_r.state   = LPMS_RESUME;
                    cnt_load       = 1'b1;
                    cnt_value      = lpms_resume_cnt(flash_asleep_i);
                end
            end
            LPMS_STOP: begin
                // reset pin held by the far side long enough
                if (!wake_pin_n_i || !reset_pin_n_i) begin
                    next_r.osc_en = 1'b1;
                    next_r.state  = LPMS_OSC;
                end
            end
            LPMS_OSC: begin
                // pin stays low until oscillator stable
                if (wake_pin_n_i && osc_stable_i) begin
                    next_r.pll_en = 1'b1;
                    next_r.state  = LPMS_LOCK;
                    cnt_load      = 1'b1;
                    cnt_value     = CNT_W'(PLL_LOCK_CYCLES - 1);
                end
            end
            LPMS_LOCK: begin
                if (cnt_zero) begin
                    next_r.core_en = 1'b1;
                    next_r.sys_en  = 1'b1;
                    next_r.xclk_en = 1'b1;
                    next_r.per_en  = 1'b1;
                    next_r.state   = LPMS_RESUME;
                    cnt_load       = 1'b1;
                    cnt_value      = lpms_resume_cnt(flash_asleep_i);
                end
            end
            LPMS_RESUME: begin
                if (cnt_zero) begin
                    next_r.resume = 1'b1;
                    next_r.irq    = wake_irq_en_i;
                    next_r.state  = LPMS_RUN;
                end
            end
            default: begin
                next_r.state = LPMS_RUN;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r.state   <= LPMS_RUN;
            r.mode    <= MODE_CLK_GATED;
            r.sys_en  <= 1'b1;
            r.per_en  <= 1'b1;
            r.xclk_en <= 1'b1;
            r.core_en <= 1'b1;
            r.osc_en  <= 1'b1;
            r.pll_en  <= 1'b1;
            r.resume  <= 1'b0;
            r.irq     <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    assign system_clock_en_o          = r.sys_en;
    assign periph_clock_en_o          = r.per_en;
    assign external_clock_output_en_o = r.xclk_en;
    assign core_clock_input_en_o      = r.core_en;
    assign osc_en_o                   = r.osc_en;
    assign pll_en_o                   = r.pll_en;
    assign cpu_resume_o               = r.resume;
    assign wake_irq_o                 = r.irq;
    assign osc_start_async_o          = osc_async;
endmodule : lpms_sequencer
`default_nettype wire

//--- lpms_pkg.sv
// package of constants and types for the low-power mode sequencer
package lpms_pkg;
    localparam int unsigned SYS_CLK_HZ        = 50_000_000;
    localparam int unsigned DRAIN_CYCLES      = 32;
    localparam int unsigned CLKOUT_LOW_MIN    = 32;
    localparam int unsigned CLKOUT_LOW_MAX    = 45;
    localparam int unsigned RESUME_FAST_MAX   = 100;
    localparam int unsigned RESUME_SLOW_MAX   = 1125;
    localparam int unsigned PLL_LOCK_CYCLES   = 131072;
    localparam int unsigned QUAL_BASE         = 2;
    localparam int unsigned QUAL_W            = 6;
    localparam int unsigned CNT_W             = 18;
    // drain count, qualifier base and resume delays used inside the bounds
    localparam logic [CNT_W-1:0] DRAIN_CNT    = 18'h0001f;
    localparam logic [CNT_W-1:0] FAST_RESUME  = 18'h00010;
    localparam logic [CNT_W-1:0] SLOW_RESUME  = 18'h00400;
    localparam logic [CNT_W-1:0] QUAL_BASE_CNT = 18'h00002;
    localparam logic MODE_CLK_GATED           = 1'b0;
    localparam logic MODE_DEEP_STOP           = 1'b1;
    typedef enum logic [6:0] {
        LPMS_RUN    = 7'h01,
        LPMS_DRAIN  = 7'h02,
        LPMS_GATED  = 7'h04,
        LPMS_STOP   = 7'h08,
        LPMS_OSC    = 7'h10,
        LPMS_LOCK   = 7'h20,
        LPMS_RESUME = 7'h40
    } lpms_state_e;
endpackage : lpms_pkg

//--- lpms_counter.sv
// loadable down counter with zero flag
`timescale 1ns/1ps
`default_nettype none
module lpms_counter
    import lpms_pkg::*;
(
    // clock and reset
    input  wire logic             mclk_i,
    input  wire logic             rst_n_i,
    // control
    input  wire logic             load_i,
    input  wire logic [CNT_W-1:0] value_i,
    // status
    output logic                  zero_o
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
    } lpms_cnt_s;
    lpms_cnt_s r;
    lpms_cnt_s next_r;
    always_comb begin
        next_r = r;
        if (load_i) begin
            next_r.cnt = value_i;
        end else if (r.cnt != '0) begin
            next_r.cnt = r.cnt - 18'h00001;
        end
    end
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
    assign zero_o = (r.cnt == '0) && !load_i;
endmodule : lpms_counter
`default_nettype wire

//--- lpms_wake_qual.sv
// wake pin qualifier: low level held for a configured count
`timescale 1ns/1ps
`default_nettype none
module lpms_wake_qual
    import lpms_pkg::*;
(
    // clock and reset
    input  wire logic              mclk_i,
    input  wire logic              rst_n_i,
    // configuration
    input  wire logic              qual_en_i,
    input  wire logic [QUAL_W-1:0] qual_count_i,
    // wake pin level, active low
    input  wire logic              wake_n_i,
    // qualified wake
    output logic                   wake_o
);
    typedef struct packed {
        logic [QUAL_W:0] run;
        logic            wake;
    } lpms_qual_s;
    lpms_qual_s r;
    lpms_qual_s next_r;
    always_comb begin
        next_r = r;
        if (wake_n_i) begin
            next_r.run  = '0;
            next_r.wake = 1'b0;
        end else begin
            if (r.run != '1) begin
                next_r.run = r.run + 7'h01;
            end
            // held for two plus count cycles
            next_r.wake = !qual_en_i ||
                (r.run >= ({1'b0, qual_count_i} + 7'h01));
        end
    end
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
    assign wake_o = r.wake;
endmodule : lpms_wake_qual
`default_nettype wire

//--- lpms_sequencer_asserts.sv
// port checker for the low-power mode sequencer
`timescale 1ns/1ps
`default_nettype none
module lpms_seq_chk
    import lpms_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // cpu side and pins
    input wire logic lp_entry_i,
    input wire logic mode_sel_i,
    input wire logic flash_asleep_i,
    input wire logic crystal_src_i,
    input wire logic wake_irq_en_i,
    input wire logic wake_pin_n_i,
    // outputs watched
    input wire logic system_clock_en_o,
    input wire logic periph_clock_en_o,
    input wire logic external_clock_output_en_o,
    input wire logic core_clock_input_en_o,
    input wire logic osc_en_o,
    input wire logic pll_en_o,
    input wire logic cpu_resume_o,
    input wire logic wake_irq_o,
    input wire logic osc_start_async_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    AST_XCLK_WINDOW: assert property (lp_entry_i && external_clock_output_en_o |->
        ##32 external_clock_output_en_o ##[1:13] !external_clock_output_en_o)
        else $error("external clock output low outside 32..45 cycles");
    AST_GATED_DRAIN: assert property (lp_entry_i && !mode_sel_i && system_clock_en_o |->
        ##32 system_clock_en_o ##[1:13]
        (!system_clock_en_o && !periph_clock_en_o && pll_en_o))
        else $error("clock-gated entry timing or clock state wrong");
    AST_STOP_DRAIN: assert property (lp_entry_i && mode_sel_i && system_clock_en_o |->
        ##32 core_clock_input_en_o ##[1:13]
        (!core_clock_input_en_o && !pll_en_o && !periph_clock_en_o))
        else $error("deep-stop entry timing or clock state wrong");
    AST_CRYSTAL_OFF: assert property ($fell(core_clock_input_en_o) && crystal_src_i
        |-> !osc_en_o)
        else $error("oscillator left on in deep stop with crystal");
    AST_ASYNC_START: assert property (!wake_pin_n_i && !core_clock_input_en_o &&
        !pll_en_o && !osc_en_o |-> osc_start_async_o)
        else $error("no async oscillator start on wake pin low");
    AST_OSC_ON: assert property ($fell(wake_pin_n_i) && !core_clock_input_en_o &&
        !pll_en_o |-> ##[1:2] osc_en_o)
        else $error("oscillator not enabled after wake pin fall");
    AST_LOCK_HOLD: assert property ($rose(pll_en_o) |->
        (wake_pin_n_i && !core_clock_input_en_o)[*8])
        else $error("pll lock started without release or core clock early");
    AST_FAST_RESUME: assert property ($rose(system_clock_en_o) && !flash_asleep_i
        |-> ##[1:98] cpu_resume_o)
        else $error("resume late with flash active");
    // cycles since clocks came back with flash asleep
    logic        slow_run;
    logic [10:0] slow_cnt;
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            slow_run <= 1'b0;
            slow_cnt <= 11'h000;
        end else if (cpu_resume_o) begin
            slow_run <= 1'b0;
        end else if ($rose(system_clock_en_o) && flash_asleep_i) begin
            slow_run <= 1'b1;
            slow_cnt <= 11'h000;
        end else if (slow_run) begin
            slow_cnt <= slow_cnt + 11'h001;
        end
    end
    AST_SLOW_RESUME: assert property (slow_run |-> slow_cnt < 11'h463)
        else $error("resume late with flash asleep");
    AST_IRQ_PAIR: assert property (cpu_resume_o |-> wake_irq_o == wake_irq_en_i)
        else $error("wake interrupt does not follow its enable");
    AST_IRQ_PULSE: assert property (wake_irq_o |-> cpu_resume_o ##1 !cpu_resume_o)
        else $error("wake interrupt not a one-cycle pulse with resume");

    cover property (lp_entry_i && mode_sel_i);
    cover property ($rose(pll_en_o));
    cover property (cpu_resume_o && wake_irq_o);
endmodule : lpms_seq_chk

bind lpms_sequencer lpms_seq_chk chk_u (.mclk_i, .rst_n_i, .lp_entry_i, .mode_sel_i,
    .flash_asleep_i, .crystal_src_i, .wake_irq_en_i, .wake_pin_n_i, .system_clock_en_o,
    .periph_clock_en_o, .external_clock_output_en_o, .core_clock_input_en_o, .osc_en_o,
    .pll_en_o, .cpu_resume_o, .wake_irq_o, .osc_start_async_o);
`default_nettype wire

//--- lpms_wake_src.sv
// wake source model driving the active-low wake pin
`timescale 1ns/1ps
`default_nettype none
module lpms_wake_src (
    // clock and control
    input  wire logic       mclk_i,
    input  wire logic       go_i,
    input  wire logic [7:0] hold_i,
    input  wire logic       osc_stable_i,
    // wake pin, pull-up when released
    output logic            wake_pin_n_o
);
    int cnt;
    int stab;
    bit held;
    // released pin sits at its pull-up level
    assign wake_pin_n_o = !held;
    always @(posedge mclk_i) begin
        if (go_i && !held) begin
            held <= 1'b1;
            cnt <= 0;
            stab <= 0;
        end else if (held) begin
            cnt <= cnt + 1;
            stab <= osc_stable_i ? stab + 1 : 0;
            if (cnt + 1 >= hold_i && stab >= 2) held <= 1'b0;
        end
    end
endmodule : lpms_wake_src
`default_nettype wire

//--- testbench.sv
// testbench for the low-power mode sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import lpms_pkg::*;
    typedef struct {logic fa; logic qe; logic [5:0] qc; logic ie; logic [7:0] hd; int bd;}
        lpms_row_s;
    logic              mclk_i, rst_n_i, lp, mode, fa, xtal, ie, qe, ostab, go, wpin, rpin;
    logic [QUAL_W-1:0] qc;
    logic [7:0]        hold;
    logic              sys, per, xclk, core, osc, pll, res, irq, oasync;
    int                err_total, samples_checked, i, n;
    lpms_row_s rows[4] = '{'{0,0,0,1,3,100}, '{1,0,0,0,3,1125},
                          '{0,1,5,1,8,107}, '{1,1,63,1,66,1190}};

    lpms_sequencer dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .lp_entry_i(lp),
        .mode_sel_i(mode), .flash_asleep_i(fa), .crystal_src_i(xtal), .wake_irq_en_i(ie),
        .qual_en_i(qe), .wake_qual_count_i(qc), .wake_pin_n_i(wpin), .reset_pin_n_i(rpin),
        .osc_stable_i(ostab), .system_clock_en_o(sys), .periph_clock_en_o(per),
        .external_clock_output_en_o(xclk), .core_clock_input_en_o(core), .osc_en_o(osc),
        .pll_en_o(pll), .cpu_resume_o(res), .wake_irq_o(irq), .osc_start_async_o(oasync));
    lpms_wake_src src_u (.mclk_i(mclk_i), .go_i(go), .hold_i(hold), .osc_stable_i(ostab),
        .wake_pin_n_o(wpin));

    task automatic final_report();
        if (err_total == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic enter(input logic m);
        @(negedge mclk_i) begin lp = 1'b1; mode = m; end
        @(negedge mclk_i) lp = 1'b0;
        repeat (31) @(negedge mclk_i);
        chk(xclk, 1'b1);
        n = 0;
        while (xclk && n < 14) begin
            @(negedge mclk_i);
            n++;
        end
        chk(xclk, 1'b0);
    endtask : enter

    task automatic pulse_go();
        @(negedge mclk_i) go = 1'b1;
        @(negedge mclk_i) go = 1'b0;
    endtask : pulse_go

    task automatic wake(input int bd);
        pulse_go();
        n = 0;
        while (res !== 1'b1 && n < bd + 4) begin
            @(negedge mclk_i);
            n++;
        end
        chk(n <= bd, 1'b1);
        if (n >= bd + 4) final_report();
    endtask : wake

    initial begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end

    initial begin
        {lp, mode, fa, xtal, ie, qe, go, qc, err_total, samples_checked} = '0;
        ostab = 1'b1;
        rpin = 1'b1;
        hold = 8'h03;
        rst_n_i = 1'b0;
        repeat (4) @(negedge mclk_i);
        rst_n_i = 1'b1;
        for (i = 0; i < 4; i++) begin
            {fa, qe, qc, ie, hold} = {rows[i].fa, rows[i].qe, rows[i].qc, rows[i].ie, rows[i].hd};
            enter(1'b0);
            chk({sys, per, pll}, 3'h1);
            wake(rows[i].bd);
            chk(irq, rows[i].ie);
            repeat (3) @(negedge mclk_i);
        end
        // qualified wake too short is refused
        {fa, qe, qc, ie, hold} = {1'b0, 1'b1, 6'h05, 1'b1, 8'h03};
        enter(1'b0);
        pulse_go();
        repeat (20) @(negedge mclk_i);
        chk(sys, 1'b0);
        hold = 8'h08;
        wake(107);
        repeat (3) @(negedge mclk_i);
        // reset pin wake from clock-gated mode
        qe = 1'b0;
        enter(1'b0);
        @(negedge mclk_i) rpin = 1'b0;
        repeat (9) @(negedge mclk_i);
        rpin = 1'b1;
        n = 0;
        while (res !== 1'b1 && n < 95) begin
            @(negedge mclk_i);
            n++;
        end
        chk(n <= 91, 1'b1);
        chk(irq, 1'b1);
        if (n >= 95) final_report();
        repeat (3) @(negedge mclk_i);
        // deep stop with crystal source
        {xtal, ostab, qe, hold} = {1'b1, 1'b0, 1'b0, 8'h03};
        enter(1'b1);
        chk({core, osc, pll, per}, 4'h0);
        @(negedge mclk_i) go = 1'b1;
        @(negedge mclk_i) go = 1'b0;
        chk(oasync, 1'b1);
        repeat (2) @(negedge mclk_i);
        chk(osc, 1'b1);
        repeat (8) @(negedge mclk_i);
        chk(wpin, 1'b0);
        ostab = 1'b1;
        n = 0;
        while (pll !== 1'b1 && n < 10) begin
            @(negedge mclk_i);
            n++;
        end
        chk({pll, wpin}, 2'h3);
        repeat (200) @(negedge mclk_i);
        chk(core, 1'b0);
        // second reset in mid-lock
        rst_n_i = 1'b0;
        @(negedge mclk_i);
        chk({sys, per, xclk, core, osc, pll, res, irq, oasync}, 9'h1f8);
        rst_n_i = 1'b1;
        enter(1'b0);
        chk({sys, per, pll}, 3'h1);
        final_report();
    end
endmodule : testbench
`default_nettype wire
